// ---- verilog/byte_timer_defs.vh ----
// How it works
// [R1] Stopped low counter keeps its match buffer equal to the low reload; running reloads at zero.
// [R2] Same for the high counter with the high reload register.
// [R3] Split mode: each byte raises a match signal when its count equals its match buffer; cascaded, both signals need both bytes to match.
// [R4] Low count byte is a read-only 8-bit up-counter stepped by the prescaler pulse, or by event ticks in split mode with event clock.
// [R5] High byte steps on low overflow when cascaded, on prescaler pulse when split.
// [R6] Read-select bit 3 maps capture values onto the two counter addresses.
// [R7] Split mode: upper enable bit 7 low holds high counter at zero, buffer tracking.
// [R8] Split mode: upper match flag bit 6 sets when running high count becomes zero.
// [R9] Split mode: bit 5 and upper match flag request the timer interrupt.
// [R10] Bit 4 low gives one cascaded 16-bit counter, high gives two 8-bit timers.
// [R11] Run bit 2 low holds timer at zero with buffer tracking; split mode: low only.
// [R12] Match flag bit 1 sets when the running timer becomes zero; software clears it.
// [R13] Enable bit 0 and match flag request the timer interrupt.
// [R14] Capture select codes pick event lines 0, 2, 4, 5 for the low capture.
// [R15] Split mode: high capture uses event lines 1, 3, 5, 4.
// [R16] Upper capture flag sets on high capture in split mode only.
// [R17] Lower capture flag sets on low capture, or on the joint 16-bit capture.
// [R18] Software clears each capture flag after reading its capture value.
// [R19] Capture enable bit 0 with either capture flag requests the interrupt.
// [R20] Clock select picks system clock, event input, slow or fast oscillator.
// [R21] Event select bit 5 picks event line 2 or event line 3.
// [R22] Prescaler emits one pulse every divider field plus one count clocks.
// [R23] Prescaler pulses when count equals divider; clears when stopped or on a pulse.
// [R24] In 16-bit mode a capture copies both counter bytes at once.
// [R25] Each interrupt request stays high while its flag and enable are both set; the upper one only in split mode.
`ifndef BYTE_TIMER_DEFS_VH
`define BYTE_TIMER_DEFS_VH
`define ADR_LOW_RELOAD 16'h7F18
`define ADR_HIGH_RELOAD 16'h7F19
`define ADR_LOW_COUNT 16'h7F1A
`define ADR_HIGH_COUNT 16'h7F1B
`define ADR_RUN_CTRL 16'h7F1C
`define ADR_CAPT_CTRL 16'h7F1D
`define ADR_CLK_CTRL 16'h7F1E
`define RC_UPPER_EN 7
`define RC_UPPER_FLAG 6
`define RC_UPPER_IE 5
`define RC_SPLIT 4
`define RC_RDSEL 3
`define RC_RUN 2
`define RC_FLAG 1
`define RC_IE 0
`define CC_SEL_HI 4
`define CC_SEL_LO 3
`define CC_UFLAG 2
`define CC_LFLAG 1
`define CC_IE 0
`define CC_WMASK 8'h1F
`define KC_COUNT_CLOCK_SELECT_HI 7
`define KC_COUNT_CLOCK_SELECT_LO 6
`define KC_EVSEL 5
`define KC_PR_HI 3
`define KC_PR_LO 0
`define KC_WMASK 8'hEF
`define CK_SYS 2'h0
`define CK_EVENT 2'h1
`define CK_SLOW 2'h2
`define CK_FAST 2'h3
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define BYTE_MAX 8'hFF
`define PR_ZERO 4'h0
`define PR_ONE 4'h1
`endif

// ---- verilog/edge_sync.v ----
`timescale 1ns/1ns
// Three-stage synchroniser; a rising edge counts once stages two and three agree high.
module edge_sync (
  input wire clk_sys_i, // System clock.
  input wire rst_i, // Synchronous reset.
  input wire d_i, // Asynchronous input.
  output reg rise_o // One-cycle pulse on a settled rising edge.
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg lvl_q;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      rise_o <= 1'b0;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
        rise_o <= s3_q & ~lvl_q;
      end
    end
  end
endmodule

// ---- verilog/byte_timer.v ----
// Chosen here: the Wishbone register port.
`timescale 1ns/1ns
`include "byte_timer_defs.vh"
module byte_timer (
  input wire clk_sys_i, // System clock, 100 MHz.
  input wire rst_i, // Synchronous reset, active high.
  input wire [31:0] adr_i, // Wishbone byte address.
  input wire [31:0] dat_i, // Wishbone write data.
  output reg [31:0] dat_o, // Wishbone read data.
  input wire [3:0] sel_i, // Wishbone byte selects.
  input wire we_i, // Wishbone write enable.
  input wire cyc_i, // Wishbone cycle.
  input wire stb_i, // Wishbone strobe.
  output reg ack_o, // Wishbone acknowledge.
  output reg err_o, // Wishbone error on unmapped address.
  input wire event_line_0_i, // External event line 0.
  input wire event_line_1_i, // External event line 1.
  input wire event_line_2_i, // External event line 2.
  input wire event_line_3_i, // External event line 3.
  input wire event_line_4_i, // External event line 4.
  input wire event_line_5_i, // External event line 5.
  input wire slow_oscillator_i, // Slow oscillator input.
  input wire fast_oscillator_i, // Fast oscillator input.
  output wire low_match_o, // Low byte match signal.
  output wire high_match_o, // High byte match signal.
  output wire irq_o // Interrupt request, level.
);
  // Each event line and oscillator enters through a synchroniser.
  wire [7:0] pin_rise;
  wire [7:0] pin_raw;
  assign pin_raw = {fast_oscillator_i, slow_oscillator_i, event_line_5_i, event_line_4_i,
                    event_line_3_i, event_line_2_i, event_line_1_i, event_line_0_i};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      edge_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .d_i(pin_raw[gi]),
        .rise_o(pin_rise[gi])
      );
    end
  endgenerate

  reg [7:0] low_reload_q;
  reg [7:0] high_reload_q;
  reg [7:0] run_ctrl_q;
  reg [7:0] capt_ctrl_q;
  reg [7:0] clk_ctrl_q;
  reg [7:0] low_count_q;
  reg [7:0] high_count_q;
  reg [7:0] low_buf_q;
  reg [7:0] high_buf_q;
  reg [7:0] low_capt_q;
  reg [7:0] high_capt_q;
  reg [3:0] pre_q;

  wire split = run_ctrl_q[`RC_SPLIT]; // R10
  wire run_lo = run_ctrl_q[`RC_RUN];
  wire run_hi_en = run_ctrl_q[`RC_UPPER_EN];
  wire [1:0] count_clock_select = clk_ctrl_q[`KC_COUNT_CLOCK_SELECT_HI:`KC_COUNT_CLOCK_SELECT_LO];
  wire [3:0] pr = clk_ctrl_q[`KC_PR_HI:`KC_PR_LO];
  wire [1:0] csel = capt_ctrl_q[`CC_SEL_HI:`CC_SEL_LO];

  // Low counter runs on the run bit; in split mode the high counter runs on its own bit.
  wire low_run = run_lo; // R11
  wire high_run = split ? run_hi_en : run_lo; // R7 R11
  wire pre_run = low_run | (split & run_hi_en);

  // Event count source.
  wire ev_tick = clk_ctrl_q[`KC_EVSEL] ? pin_rise[3] : pin_rise[2]; // R21

  reg pre_tick;
  always @* begin
    case (count_clock_select) // R20
      `CK_SYS: pre_tick = 1'b1;
      `CK_EVENT: pre_tick = split ? 1'b1 : ev_tick;
      `CK_SLOW: pre_tick = pin_rise[6];
      `CK_FAST: pre_tick = pin_rise[7];
      default: pre_tick = 1'b0;
    endcase
  end

  wire pre_match = pre_run & pre_tick & (pre_q == pr); // R22 R23
  // In split mode with event clock the low byte counts events directly.
  wire low_step = (split && count_clock_select == `CK_EVENT) ? ev_tick : pre_match; // R4

  wire low_hit = (low_count_q == low_buf_q);
  wire high_hit = (high_count_q == high_buf_q);
  wire full_hit = low_hit & high_hit;
  assign low_match_o = low_run & (split ? low_hit : full_hit); // R3
  assign high_match_o = high_run & (split ? high_hit : full_hit); // R3

  // In cascaded mode the 16-bit match wraps both bytes to zero.
  wire low_wrap = low_run & low_step & low_match_o; // R23
  wire low_ovf = low_run & low_step & (low_count_q == `BYTE_MAX);
  wire high_step = split ? pre_match : (low_ovf & ~low_wrap); // R5
  wire high_wrap = split ? (high_run & high_step & high_match_o) : low_wrap;

  reg [7:0] low_count_d;
  reg [7:0] high_count_d;
  always @* begin
    low_count_d = low_count_q;
    if (!low_run || low_wrap)
      low_count_d = `BYTE_ZERO;
    else if (low_step)
      low_count_d = low_count_q + `BYTE_ONE; // R4
    high_count_d = high_count_q;
    if (!high_run || high_wrap)
      high_count_d = `BYTE_ZERO;
    else if (high_step)
      high_count_d = high_count_q + `BYTE_ONE; // R5
  end

  wire low_zero = low_run & (low_count_d == `BYTE_ZERO) & (low_count_q != `BYTE_ZERO);
  wire high_zero = high_run & (high_count_d == `BYTE_ZERO) & (high_count_q != `BYTE_ZERO);
  wire low_flag_set = split ? low_zero : (low_zero & high_count_d == `BYTE_ZERO);
  wire low_flag_ev = low_flag_set | (low_wrap & low_count_q == `BYTE_ZERO);
  wire high_flag_ev = split & (high_zero | (high_wrap & high_count_q == `BYTE_ZERO));

  // Capture triggers.
  reg lo_cap;
  reg hi_cap;
  always @* begin
    case (csel) // R14
      2'h0: lo_cap = pin_rise[0];
      2'h1: lo_cap = pin_rise[2];
      2'h2: lo_cap = pin_rise[4];
      2'h3: lo_cap = pin_rise[5];
      default: lo_cap = 1'b0;
    endcase
    if (!split)
      hi_cap = lo_cap; // R24
    else begin
      case (csel) // R15
        2'h0: hi_cap = pin_rise[1];
        2'h1: hi_cap = pin_rise[3];
        2'h2: hi_cap = pin_rise[5];
        2'h3: hi_cap = pin_rise[4];
        default: hi_cap = 1'b0;
      endcase
    end
  end

  // Register bus decode; data for byte-addressed registers sits in the low lane.
  wire req = cyc_i & stb_i & ~ack_o & ~err_o;
  wire [15:0] adr = adr_i[15:0];
  wire mapped = (adr_i[31:16] == 16'h0000) && (adr >= `ADR_LOW_RELOAD) && (adr <= `ADR_CLK_CTRL);
  wire wr = req & mapped & we_i & sel_i[0];
  wire [7:0] wd = dat_i[7:0];

  reg [7:0] rd;
  always @* begin
    case (adr)
      `ADR_LOW_RELOAD: rd = low_reload_q;
      `ADR_HIGH_RELOAD: rd = high_reload_q;
      `ADR_LOW_COUNT: rd = run_ctrl_q[`RC_RDSEL] ? low_capt_q : low_count_q; // R6
      `ADR_HIGH_COUNT: rd = run_ctrl_q[`RC_RDSEL] ? high_capt_q : high_count_q; // R6
      `ADR_RUN_CTRL: rd = run_ctrl_q;
      `ADR_CAPT_CTRL: rd = capt_ctrl_q;
      `ADR_CLK_CTRL: rd = clk_ctrl_q;
      default: rd = `BYTE_ZERO;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req & mapped;
      err_o <= req & ~mapped;
      dat_o <= (req & mapped & ~we_i) ? {24'h000000, rd} : 32'h00000000;
    end
  end

  // Flags: a hardware set in the same cycle as a software clear wins.
  reg [7:0] run_ctrl_d;
  reg [7:0] capt_ctrl_d;
  always @* begin
    run_ctrl_d = run_ctrl_q;
    if (wr && adr == `ADR_RUN_CTRL)
      run_ctrl_d = wd;
    if (low_flag_ev)
      run_ctrl_d[`RC_FLAG] = 1'b1; // R12
    if (high_flag_ev)
      run_ctrl_d[`RC_UPPER_FLAG] = 1'b1; // R8
    capt_ctrl_d = capt_ctrl_q;
    if (wr && adr == `ADR_CAPT_CTRL)
      capt_ctrl_d = wd & `CC_WMASK; // R18
    if (split ? lo_cap : (lo_cap & hi_cap))
      capt_ctrl_d[`CC_LFLAG] = 1'b1; // R17
    if (split & hi_cap)
      capt_ctrl_d[`CC_UFLAG] = 1'b1; // R16
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      low_reload_q <= `BYTE_ZERO;
      high_reload_q <= `BYTE_ZERO;
      run_ctrl_q <= `BYTE_ZERO;
      capt_ctrl_q <= `BYTE_ZERO;
      clk_ctrl_q <= `BYTE_ZERO;
      low_count_q <= `BYTE_ZERO;
      high_count_q <= `BYTE_ZERO;
      low_buf_q <= `BYTE_ZERO;
      high_buf_q <= `BYTE_ZERO;
      low_capt_q <= `BYTE_ZERO;
      high_capt_q <= `BYTE_ZERO;
      pre_q <= `PR_ZERO;
    end else begin
      if (wr && adr == `ADR_LOW_RELOAD)
        low_reload_q <= wd;
      if (wr && adr == `ADR_HIGH_RELOAD)
        high_reload_q <= wd;
      if (wr && adr == `ADR_CLK_CTRL)
        clk_ctrl_q <= wd & `KC_WMASK;
      run_ctrl_q <= run_ctrl_d;
      capt_ctrl_q <= capt_ctrl_d;
      low_count_q <= low_count_d;
      high_count_q <= high_count_d;
      if (!pre_run || pre_match)
        pre_q <= `PR_ZERO; // R23
      else if (pre_tick)
        pre_q <= pre_q + `PR_ONE; // R22
      if (!low_run || low_count_d == `BYTE_ZERO)
        low_buf_q <= low_reload_q; // R1
      if (!high_run || high_count_d == `BYTE_ZERO)
        high_buf_q <= high_reload_q; // R2
      if (lo_cap)
        low_capt_q <= low_count_q; // R24
      if (hi_cap)
        high_capt_q <= high_count_q; // R24
    end
  end

  wire irq_timer = run_ctrl_q[`RC_IE] & run_ctrl_q[`RC_FLAG]; // R13
  wire irq_upper = split & run_ctrl_q[`RC_UPPER_IE] & run_ctrl_q[`RC_UPPER_FLAG]; // R9
  wire irq_capt = capt_ctrl_q[`CC_IE] & (capt_ctrl_q[`CC_UFLAG] | capt_ctrl_q[`CC_LFLAG]); // R19
  assign irq_o = irq_timer | irq_upper | irq_capt; // R25
endmodule

// ---- bench/byte_timer_assertions.sv ----
`timescale 1ns/1ns
module byte_timer_assertions (
  input wire logic clk_sys_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic [31:0] adr_i, // Address.
  input wire logic [31:0] dat_i, // Write data.
  input wire logic [31:0] dat_o, // Read data.
  input wire logic [3:0] sel_i, // Selects.
  input wire logic we_i, // Write.
  input wire logic cyc_i, // Cycle.
  input wire logic stb_i, // Strobe.
  input wire logic ack_o, // Ack.
  input wire logic err_o, // Error.
  input wire logic event_line_0_i, // Event 0.
  input wire logic event_line_1_i, // Event 1.
  input wire logic event_line_2_i, // Event 2.
  input wire logic event_line_3_i, // Event 3.
  input wire logic event_line_4_i, // Event 4.
  input wire logic event_line_5_i, // Event 5.
  input wire logic slow_oscillator_i, // Slow clock.
  input wire logic fast_oscillator_i, // Fast clock.
  input wire logic low_match_o, // Low match.
  input wire logic high_match_o, // High match.
  input wire logic irq_o // Interrupt.
);
  logic req;
  logic hit;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign hit = adr_i[31:16] == 16'h0000 && adr_i[15:0] >= 16'h7F18 && adr_i[15:0] <= 16'h7F1E;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_err_pulse: assert property (err_o |=> !err_o)
    else $error("err held too long");
  a_mapped_ack: assert property (req && hit |=> ack_o && !err_o)
    else $error("mapped access not acked");
  a_unmapped_err: assert property (req && !hit |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  a_answer_cause: assert property ((ack_o || err_o) |-> $past(req))
    else $error("answer without request");
  a_answer_excl: assert property (!(ack_o && err_o))
    else $error("ack and err together");
  a_idle_data: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data outside ack");
  a_byte_data: assert property (dat_o[31:8] == 24'h000000)
    else $error("upper read data nonzero");
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !low_match_o && !high_match_o)
    else $error("outputs active after reset");
  cover property (ack_o && we_i);
  cover property (err_o);
  cover property ($rose(irq_o));
endmodule
bind byte_timer byte_timer_assertions chk (.*);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  logic clk_sys_i = 0;
  logic rst_i = 1;
  logic [31:0] adr_i = 0;
  logic [31:0] dat_i = 0;
  logic [3:0] sel_i = 0;
  logic we_i = 0;
  logic cyc_i = 0;
  logic stb_i = 0;
  logic [7:0] ext = 0;
  logic [31:0] dat_o;
  logic ack_o, err_o, low_match_o, high_match_o, irq_o;
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] q;
  logic e;
  int src[4] = '{2, 3, 6, 7};
  logic [7:0] ck[4] = '{8'h40, 8'h60, 8'h80, 8'hC0};
  int lo[4] = '{0, 2, 4, 5};
  int hi[4] = '{1, 3, 5, 4};
  byte_timer uut (.*, .event_line_0_i(ext[0]), .event_line_1_i(ext[1]),
    .event_line_2_i(ext[2]), .event_line_3_i(ext[3]), .event_line_4_i(ext[4]),
    .event_line_5_i(ext[5]), .slow_oscillator_i(ext[6]), .fast_oscillator_i(ext[7]));
  always #5 clk_sys_i = ~clk_sys_i;
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys_i);
    adr_i <= {16'h0000, a};
    dat_i <= {24'h000000, d};
    we_i <= w;
    sel_i <= 4'hF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    // The answer is taken at the rising edge that samples ack or err high, then released there.
    do @(posedge clk_sys_i); while (!(ack_o || err_o));
    q = dat_o[7:0];
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] x);
    wb(a, 1'b0, 8'h00);
    chk({e, q & m}, {1'b0, x});
  endtask
  task pulse(input int i);
    @(posedge clk_sys_i);
    ext[i] <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    ext[i] <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  function automatic logic mt(input logic h);
    return h ? high_match_o : low_match_o;
  endfunction
  // Measures the distance between two rising edges of a match output.
  task per(input logic h, input int x);
    int c;
    c = 0;
    do @(negedge clk_sys_i); while (mt(h));
    do @(negedge clk_sys_i); while (!mt(h));
    do begin
      @(negedge clk_sys_i);
      c++;
    end while (mt(h));
    do begin
      @(negedge clk_sys_i);
      c++;
    end while (!mt(h));
    chk(c, x);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++)
      rdc(16'h7F18 + i[15:0], 8'hFF, 8'h00);
    wb(16'h7F1F, 1'b0, 8'h00);
    chk(e, 1'b1);
    wb(16'h7F1A, 1'b1, 8'h55);
    rdc(16'h7F1A, 8'hFF, 8'h00);
    wb(16'h7F1E, 1'b1, 8'hFF);
    rdc(16'h7F1E, 8'hFF, 8'hEF);
    $display("test registers done");
    wb(16'h7F18, 1'b1, 8'h02);
    wb(16'h7F1C, 1'b1, 8'h05);
    for (int p = 0; p < 4; p++) begin
      wb(16'h7F1E, 1'b1, p[7:0]);
      per(1'b0, 3 * (p + 1));
    end
    chk(irq_o, 1'b1);
    rdc(16'h7F1C, 8'h02, 8'h02);
    wb(16'h7F1C, 1'b1, 8'h00);
    chk(irq_o, 1'b0);
    rdc(16'h7F1A, 8'hFF, 8'h00);
    wb(16'h7F18, 1'b1, 8'h01);
    wb(16'h7F1C, 1'b1, 8'h04);
    per(1'b0, 8);
    wb(16'h7F1C, 1'b1, 8'h00);
    $display("test cascaded done");
    wb(16'h7F19, 1'b1, 8'h02);
    wb(16'h7F1E, 1'b1, 8'h01);
    wb(16'h7F1C, 1'b1, 8'hB0);
    per(1'b1, 6);
    chk(irq_o, 1'b1);
    rdc(16'h7F1C, 8'h42, 8'h40);
    wb(16'h7F1C, 1'b1, 8'h10);
    rdc(16'h7F1B, 8'hFF, 8'h00);
    chk(irq_o, 1'b0);
    $display("test split done");
    wb(16'h7F18, 1'b1, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      wb(16'h7F1E, 1'b1, ck[i]);
      wb(16'h7F1C, 1'b1, 8'h04);
      repeat (5) pulse(src[i]);
      rdc(16'h7F1A, 8'hFF, 8'h05);
      wb(16'h7F1C, 1'b1, 8'h0C);
      rdc(16'h7F1A, 8'hFF, 8'h00);
      wb(16'h7F1C, 1'b1, 8'h00);
    end
    $display("test clock sources done");
    for (int m = 0; m < 2; m++) begin
      wb(16'h7F1C, 1'b1, m ? 8'h10 : 8'h00);
      for (int c = 0; c < 4; c++) begin
        wb(16'h7F1D, 1'b1, {3'b000, c[1:0], 3'b001});
        pulse(hi[c]);
        rdc(16'h7F1D, 8'h06, m ? 8'h04 : 8'h00);
        pulse(lo[c]);
        rdc(16'h7F1D, 8'h06, m ? 8'h06 : 8'h02);
        chk(irq_o, 1'b1);
        wb(16'h7F1D, 1'b1, 8'h00);
        rdc(16'h7F1D, 8'h06, 8'h00);
      end
    end
    $display("test capture done");
    stop_test;
  end
endmodule
